// file: core/wavegen_pkg.sv
package wavegen_pkg;

  localparam int unsigned num_channels = 2;
  localparam int unsigned count_width  = 8;

  // Register byte addresses (offsets 0x0d and 0x1b are not word aligned, kept as indices)
  localparam logic [7:0]  driver_control_index    = 8'h0d;
  localparam logic [7:0]  period_value_index      = 8'h1b;
  localparam logic [7:0]  mode_control_index      = 8'h00;
  localparam logic [7:0]  compare_0_index         = 8'h18;
  localparam logic [7:0]  compare_1_index         = 8'h19;
  localparam logic [7:0]  period_buffer_index     = 8'h2f;
  localparam logic [7:0]  status_index            = 8'h01;
  localparam logic [9:0]  driver_control_addr     = {driver_control_index, 2'b00};
  localparam logic [9:0]  period_value_addr       = {period_value_index, 2'b00};
  localparam logic [9:0]  mode_control_addr       = {mode_control_index, 2'b00};
  localparam logic [9:0]  compare_0_addr          = {compare_0_index, 2'b00};
  localparam logic [9:0]  compare_1_addr          = {compare_1_index, 2'b00};
  localparam logic [9:0]  period_buffer_addr      = {period_buffer_index, 2'b00};
  localparam logic [9:0]  status_addr             = {status_index, 2'b00};

  // Reset values
  localparam logic [7:0]  driver_control_reset    = 8'h00;
  localparam logic [7:0]  period_value_reset      = 8'hff;
  localparam logic [7:0]  compare_reset           = 8'h00;

  // Mode control field positions
  localparam int unsigned mode_lsb       = 0;
  localparam int unsigned prescale_lsb   = 2;
  localparam int unsigned direction_bit  = 5;
  localparam int unsigned enable_bit     = 7;

  // Synchronisation of period writes, in counter clock cycles of pclk
  localparam int unsigned sync_cycles    = 2;

  typedef enum logic [1:0] {
    match_frequency_mode,
    single_slope_pwm_mode,
    match_pwm_mode,
    normal_frequency_mode
  } wave_mode_type;

  typedef struct packed {
    logic          enable;
    logic          count_down;
    logic [2:0]    prescale_select;
    wave_mode_type mode;
  } mode_control_type;

  typedef struct packed {
    logic [count_width-1:0] top;
    logic [count_width-1:0] compare_0;
    logic [count_width-1:0] compare_1;
  } compare_set_type;

endpackage

// file: core/prescaler.sv
`timescale 1ns/10ps

module prescaler
  import wavegen_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] prescale_select,
  output logic            tick
);

  typedef struct packed {
    logic [9:0] count;
    logic       tick;
  } state_type;

  state_type state_q;
  state_type state_d;

  // Divisor minus one for each select code
  function automatic logic [9:0] divisor_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    divisor_limit = 10'h000;
      3'h1:    divisor_limit = 10'h001;
      3'h2:    divisor_limit = 10'h003;
      3'h3:    divisor_limit = 10'h007;
      3'h4:    divisor_limit = 10'h00f;
      3'h5:    divisor_limit = 10'h03f;
      3'h6:    divisor_limit = 10'h0ff;
      default: divisor_limit = 10'h3ff;
    endcase
  endfunction

  always_comb begin
    state_d      = state_q;
    state_d.tick = 1'b0;
    if (!run) begin
      state_d.count = 10'h000;
    end else if (state_q.count >= divisor_limit(prescale_select)) begin
      state_d.count = 10'h000;
      state_d.tick  = 1'b1;
    end else begin
      state_d.count = state_q.count + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign tick = state_q.tick;

endmodule // prescaler

// file: core/capture_input_sync.sv
`timescale 1ns/10ps

module capture_input_sync
  import wavegen_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [num_channels-1:0] pin_in,
  input  wire logic [num_channels-1:0] invert,
  output logic      [num_channels-1:0] trigger
);

  typedef struct packed {
    logic [num_channels-1:0] first;
    logic [num_channels-1:0] second;
    logic [num_channels-1:0] trigger;
  } state_type;

  state_type state_q;
  state_type state_d;

  always_comb begin
    state_d         = state_q;
    state_d.first   = pin_in;
    state_d.second  = state_q.first;
    state_d.trigger = state_q.second ^ invert;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign trigger = state_q.trigger;

endmodule // capture_input_sync

// file: core/timer_waveform_generator.sv
// The APB slave port was decided locally.
`timescale 1ns/10ps

// Function
// - Match frequency: compare value 0 sets period, output 0 toggles on each update.
// - Single-slope PWM: top sets period, channel compare value sets duty.
// - Counting up: output high at start or top, low at compare match.
// - Counting down: output low at start or zero, high at compare match.
// - Single-slope period lasts top plus one prescaled ticks.
// - Prescaler divides by 1, 2, 4, 8, 16, 64, 256 or 1024.
// - Match PWM: output 1 from compare 1; one-tick low pulse on output 0 per wrap.
// - Period register loads from period buffer on update; writes are synchronised.
// - Invert bit inverts both waveform output and capture trigger input of its channel.
module timer_waveform_generator
  import wavegen_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [num_channels-1:0] capture_pin,
  output logic      [num_channels-1:0] capture_trigger,
  output logic      [num_channels-1:0] waveform_output,
  output logic                         update_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    mode_control_type        control;
    logic [7:0]              driver_control;
    logic [7:0]              period_value;
    logic [7:0]              period_buffer;
    logic                    buffer_valid;
    logic [1:0]              sync_count;
    compare_set_type         compares;
    logic [7:0]              count;
    logic                    started;
    logic [num_channels-1:0] raw_wave;
    logic [num_channels-1:0] wave_out;
    logic                    update;
    logic [31:0]             rdata;
    logic                    ready;
    logic                    slverr;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic                    tick;
  logic [num_channels-1:0] trigger_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] channel_compare(input compare_set_type c,
                                                 input int unsigned ch);
    channel_compare = (ch == 0) ? c.compare_0 : c.compare_1;
  endfunction

  function automatic logic addr_hit(input logic [11:0] a, input logic [9:0] reg_addr);
    addr_hit = (a[11:10] == 2'b00) && (a[9:0] == reg_addr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  prescaler u_prescaler (
    .pclk            (pclk),
    .presetn         (presetn),
    .run             (state_q.control.enable),
    .prescale_select (state_q.control.prescale_select),
    .tick            (tick)
  );

  capture_input_sync u_capture_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (capture_pin),
    .invert  (state_q.driver_control[num_channels-1:0]),
    .trigger (trigger_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [7:0] top_now;
  logic       at_end;
  logic       apb_access;
  logic       apb_write;

  always_comb begin
    state_d        = state_q;
    state_d.update = 1'b0;
    state_d.ready  = 1'b0;
    state_d.slverr = 1'b0;
    apb_access     = psel && penable && !state_q.ready;
    apb_write      = apb_access && pwrite;

    // Period source: compare value 0 in match frequency and match PWM modes
    case (state_q.control.mode)
      match_frequency_mode: top_now = state_q.compares.compare_0;
      match_pwm_mode:       top_now = state_q.compares.compare_0;
      single_slope_pwm_mode: top_now = state_q.period_value;
      default:              top_now = state_q.period_value;
    endcase
    at_end = state_q.control.count_down ? (state_q.count == 8'h00)
                                        : (state_q.count == top_now);

    // Pending period buffer takes a few cycles to cross into the counter
    if (state_q.sync_count != 2'b00) begin
      state_d.sync_count = state_q.sync_count - 2'b01;
    end

    if (!state_q.control.enable) begin
      state_d.started = 1'b0;
      state_d.count   = 8'h00;
    end else if (tick) begin
      if (!state_q.started) begin
        state_d.started = 1'b1;
        state_d.count   = state_q.control.count_down ? top_now : 8'h00;
        for (int ch = 0; ch < num_channels; ch++) begin
          if (state_q.control.mode != match_frequency_mode) begin
            state_d.raw_wave[ch] = !state_q.control.count_down;
          end
        end
      end else begin
        // Wrap after top plus one ticks
        if (at_end) begin
          state_d.update = 1'b1;
          state_d.count  = state_q.control.count_down ? top_now : 8'h00;
        end else begin
          state_d.count = state_q.control.count_down ? state_q.count - 8'h01
                                                     : state_q.count + 8'h01;
        end
        case (state_q.control.mode)
          match_frequency_mode: begin
            if (at_end) begin
              state_d.raw_wave[0] = !state_q.raw_wave[0];
            end
          end
          single_slope_pwm_mode: begin
            for (int ch = 0; ch < num_channels; ch++) begin
              if (at_end) begin
                state_d.raw_wave[ch] = !state_q.control.count_down;
              end else if (state_q.count == channel_compare(state_q.compares, ch)) begin
                state_d.raw_wave[ch] = state_q.control.count_down;
              end
            end
          end
          match_pwm_mode: begin
            state_d.raw_wave[0] = !at_end;
            if (at_end) begin
              state_d.raw_wave[1] = !state_q.control.count_down;
            end else if (state_q.count == state_q.compares.compare_1) begin
              state_d.raw_wave[1] = state_q.control.count_down;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Buffer copied into period on update once synchronised
    if (state_d.update && state_q.buffer_valid && state_q.sync_count == 2'b00) begin
      state_d.period_value = state_q.period_buffer;
      state_d.buffer_valid = 1'b0;
    end

    state_d.wave_out = state_q.raw_wave ^ state_q.driver_control[num_channels-1:0];

    // APB slave, one wait state
    if (apb_access) begin
      state_d.ready = 1'b1;
      state_d.rdata = 32'h0000_0000;
      if (addr_hit(paddr, driver_control_addr)) begin
        if (apb_write) state_d.driver_control = {6'h00, pwdata[1:0]};
        state_d.rdata = {24'h000000, state_q.driver_control};
      end else if (addr_hit(paddr, period_value_addr)) begin
        if (apb_write) begin
          state_d.period_buffer = pwdata[7:0];
          state_d.buffer_valid  = 1'b1;
          state_d.sync_count    = 2'(sync_cycles);
        end
        state_d.rdata = {24'h000000, state_q.period_value};
      end else if (addr_hit(paddr, period_buffer_addr)) begin
        if (apb_write) begin
          state_d.period_buffer = pwdata[7:0];
          state_d.buffer_valid  = 1'b1;
          state_d.sync_count    = 2'(sync_cycles);
        end
        state_d.rdata = {24'h000000, state_q.period_buffer};
      end else if (addr_hit(paddr, mode_control_addr)) begin
        // Fields placed by the package positions; bit 6 is unused and reads zero
        if (apb_write) begin
          state_d.control.mode            = wave_mode_type'(pwdata[mode_lsb +: 2]);
          state_d.control.prescale_select = pwdata[prescale_lsb +: 3];
          state_d.control.count_down      = pwdata[direction_bit];
          state_d.control.enable          = pwdata[enable_bit];
        end
        state_d.rdata = {24'h000000, state_q.control.enable, 1'b0, state_q.control.count_down,
                         state_q.control.prescale_select, state_q.control.mode};
      end else if (addr_hit(paddr, compare_0_addr)) begin
        if (apb_write) state_d.compares.compare_0 = pwdata[7:0];
        state_d.rdata = {24'h000000, state_q.compares.compare_0};
      end else if (addr_hit(paddr, compare_1_addr)) begin
        if (apb_write) state_d.compares.compare_1 = pwdata[7:0];
        state_d.rdata = {24'h000000, state_q.compares.compare_1};
      end else if (addr_hit(paddr, status_addr)) begin
        state_d.rdata = {16'h0000, state_q.count, 4'h0, state_q.wave_out,
                         state_q.buffer_valid, state_q.started};
      end else begin
        state_d.slverr = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q                <= '0;
      state_q.driver_control <= driver_control_reset;
      state_q.period_value   <= period_value_reset;
      state_q.period_buffer  <= period_value_reset;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata          = state_q.rdata;
  assign pready          = state_q.ready;
  assign pslverr         = state_q.slverr;
  assign waveform_output = state_q.wave_out;
  assign update_pulse    = state_q.update;
  assign capture_trigger = trigger_sync;

endmodule // timer_waveform_generator

// file: verification/timer_waveform_generator_monitor.sv
`timescale 1ns/10ps

module timer_waveform_generator_monitor
  import wavegen_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [num_channels-1:0] capture_pin,
  input wire logic [num_channels-1:0] capture_trigger,
  input wire logic [num_channels-1:0] waveform_output,
  input wire logic                    update_pulse
);
  logic [1:0] inv_q;
  logic [3:0] cyc_q;
  logic       acc;
  logic       drv;
  logic       period_value_8bit;
  logic       hit;

  assign acc = psel && penable && !pready;
  assign drv = paddr == {2'b00, driver_control_addr};
  assign period_value_8bit = paddr == {2'b00, period_value_addr};
  assign hit = paddr inside {{2'b00, mode_control_addr}, {2'b00, status_addr},
                             {2'b00, driver_control_addr}, {2'b00, compare_0_addr},
                             {2'b00, compare_1_addr}, {2'b00, period_value_addr},
                             {2'b00, period_buffer_addr}};

  // Shadow of the invert bits and a settling count after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inv_q <= 2'h0;
      cyc_q <= 4'h0;
    end else begin
      if (cyc_q != 4'hf) cyc_q <= cyc_q + 4'h1;
      if (psel && penable && pready && pwrite && drv) inv_q <= pwdata[1:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  property p_ready_next; acc |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  property p_unmapped; acc && !hit |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no pslverr");
  property p_mapped; acc && hit |=> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("bad pslverr");
  property p_idle; !psel |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("pready idle");
  property p_narrow; acc && !pwrite && (drv || period_value_8bit) |=> prdata[31:8] == 24'h0; endproperty
  a_narrow: assert property (p_narrow) else $error("upper bits set");
  property p_drv_read; acc && !pwrite && drv |=> prdata[1:0] == inv_q; endproperty
  a_drv_read: assert property (p_drv_read) else $error("invert bits read");
  property p_capture;
    cyc_q == 4'hf && inv_q == $past(inv_q) && inv_q == $past(inv_q, 2) &&
    capture_pin == $past(capture_pin) && capture_pin == $past(capture_pin, 2) &&
    capture_pin == $past(capture_pin, 3) && capture_pin == $past(capture_pin, 4)
    |-> capture_trigger == (capture_pin ^ inv_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture trigger");

endmodule // timer_waveform_generator_monitor

bind timer_waveform_generator timer_waveform_generator_monitor timer_waveform_generator_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .capture_pin(capture_pin), .capture_trigger(capture_trigger),
  .waveform_output(waveform_output), .update_pulse(update_pulse));

// file: verification/tb.sv
`timescale 1ns/10ps

module tb;
  import wavegen_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, update_pulse, er, ws, we;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  capture_pin, capture_trigger, waveform_output, pv, iv;
  int          failures, compares, seed, period_value_8bit, h0, h1, n, p, c0, c1, ha;
  int          divs [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

  timer_waveform_generator timer_waveform_generator_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .capture_trigger(capture_trigger),
    .waveform_output(waveform_output), .update_pulse(update_pulse));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  function logic [11:0] ad(input logic [9:0] x);
    return {2'b00, x};
  endfunction

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wait_upd;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (update_pulse !== 1'b1 && n < 20000);
    if (update_pulse !== 1'b1) failures++;
  endtask

  // Counts one full update period and the high cycles of each output in it
  task run(input wave_mode_type md, input logic dn, input logic [2:0] ps, input logic [1:0] v,
           input int a, input int b, input int pb);
    apb(1'b1, ad(mode_control_addr), 32'h0);
    apb(1'b1, ad(driver_control_addr), {30'h0, v});
    apb(1'b1, ad(compare_0_addr), 32'(a));
    apb(1'b1, ad(compare_1_addr), 32'(b));
    apb(1'b1, ad(period_buffer_addr), 32'(pb));
    apb(1'b1, ad(mode_control_addr), {24'h0, 2'b10, dn, ps, md});
    wait_upd;
    wait_upd;
    ws = waveform_output[0];
    period_value_8bit = 0;
    h0 = 0;
    h1 = 0;
    do begin
      @(posedge pclk);
      period_value_8bit++;
      h0 += waveform_output[0];
      h1 += waveform_output[1];
    end while (update_pulse !== 1'b1 && period_value_8bit < 20000);
    we = waveform_output[0];
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 3350;
    failures = 0;
    compares = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, capture_pin} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ad(driver_control_addr), 32'h0);
    chk("drv_reset", 32'h0, rd);
    apb(1'b0, ad(period_value_addr), 32'h0);
    chk("per_reset", 32'hff, rd);
    apb(1'b0, 12'h3f0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    for (int i = 0; i < 8; i++) begin
      pv = 2'($random(seed));
      iv = 2'($random(seed));
      apb(1'b1, ad(driver_control_addr), {30'h0, iv});
      capture_pin <= pv;
      repeat (4) @(posedge pclk);
      chk("capture", {30'h0, pv ^ iv}, {30'h0, capture_trigger});
    end
    p = 8 + $unsigned($random(seed)) % 24;
    c0 = 1 + $unsigned($random(seed)) % (p - 1);
    c1 = 1 + $unsigned($random(seed)) % (p - 1);
    apb(1'b1, ad(period_buffer_addr), 32'(p));
    apb(1'b0, ad(period_value_addr), 32'h0);
    chk("per_held", 32'hff, rd);
    for (int d = 0; d < 2; d++) begin
      run(single_slope_pwm_mode, d[0], 3'h0, 2'h0, c0, c1, p);
      chk("single_slope_pwm_mode_per", p + 1, period_value_8bit);
      chk("single_slope_pwm_mode_duty", c1 - c0, h1 - h0);
      ha = h0;
      run(single_slope_pwm_mode, d[0], 3'h0, 2'h1, c0, c1, p);
      chk("single_slope_pwm_mode_inv", period_value_8bit - ha, h0);
    end
    apb(1'b0, ad(period_value_addr), 32'h0);
    chk("per_loaded", p, rd);
    for (int k = 0; k < 8; k++) begin
      run(single_slope_pwm_mode, 1'b0, 3'(k), 2'h0, 1, 2, 3);
      chk("prescale_per", divs[k] * 4, period_value_8bit);
    end
    c0 = 4 + $unsigned($random(seed)) % 40;
    run(match_frequency_mode, 1'b0, 3'h0, 2'h0, c0, 1, p);
    chk("match_frequency_mode_per", c0 + 1, period_value_8bit);
    chk("match_frequency_mode_toggle", {31'h0, ~ws}, {31'h0, we});
    run(match_pwm_mode, 1'b0, 3'h0, 2'h0, c0, 1, p);
    chk("match_pwm_mode_low", 1, period_value_8bit - h0);
    ha = h1;
    run(match_pwm_mode, 1'b0, 3'h0, 2'h0, c0, 3, p);
    chk("match_pwm_mode_out1", 2, h1 - ha);
    run(normal_frequency_mode, 1'b0, 3'h0, 2'h0, c0, 1, p);
    chk("nfrq_per", p + 1, period_value_8bit);
    apb(1'b0, ad(status_addr), 32'h0);
    chk("status", 32'h1, {30'h0, rd[1:0]});
    end_sim;
  end

  initial begin
    #5000000;
    failures++;
    end_sim;
  end

endmodule // tb
